// [src/asp_params.svh]
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// register byte offsets
`define ASP_OFS_CTRL 8'h00
`define ASP_OFS_DATA 8'h04
`define ASP_OFS_BAUD 8'h08
`define ASP_OFS_RELOAD 8'h0c
`define ASP_OFS_T1RELOAD 8'h10
`define ASP_OFS_IRQ_STAT 8'h14
`define ASP_OFS_IRQ_MASK 8'h18

// control register fields
`define ASP_CTRL_RI 0
`define ASP_CTRL_TI 1
`define ASP_CTRL_RB8 2
`define ASP_CTRL_TB8 3
`define ASP_CTRL_REN 4
`define ASP_CTRL_MPE 5
`define ASP_CTRL_MODE_LO 6
`define ASP_CTRL_MODE_HI 7

// baud configuration fields
`define ASP_BAUD_RATE_DOUBLE 0
`define ASP_BAUD_BAUD_GENERATOR_SELECT 1
`define ASP_BAUD_TIMER1_PRESCALE_LO 2
`define ASP_BAUD_TIMER1_PRESCALE_HI 3
`define ASP_BAUD_RPS_LO 4
`define ASP_BAUD_RPS_HI 5

// interrupt status bits
`define ASP_IRQ_TX 0
`define ASP_IRQ_RX 1
`define ASP_IRQ_W 2

// reset values
`define ASP_RST_BYTE 8'h00
`define ASP_RST_RELOAD 10'h000
`define ASP_RST_IRQ 2'h0
`define ASP_RST_WORD 32'h0000_0000

// mode encodings
`define ASP_MODE_0 2'h0
`define ASP_MODE_1 2'h1
`define ASP_MODE_2 2'h2
`define ASP_MODE_3 2'h3

// prescaler settings and divide counts
`define ASP_TIMER1_PRESCALE_12 2'h0
`define ASP_TIMER1_PRESCALE_1 2'h1
`define ASP_TIMER1_PRESCALE_96 2'h2
`define ASP_RPS_32 2'h1
`define ASP_PRE_1 7'h01
`define ASP_PRE_2 7'h02
`define ASP_PRE_4 7'h04
`define ASP_PRE_12 7'h0c
`define ASP_PRE_96 7'h60
`define ASP_TOP_RELOAD 10'h3ff
`define ASP_TOP_TIMER 10'h0ff

// oversampling: sixteen ticks per bit
`define ASP_PH_LAST 4'hf
`define ASP_PH_SAMPLE 4'h7
`define ASP_LEFT_8BIT 4'h9
`define ASP_LEFT_9BIT 4'ha
`define ASP_RXN_8BIT 4'h9
`define ASP_RXN_9BIT 4'ha

`endif

// [src/asp_pkg.sv]
package asp_pkg;
    typedef enum logic [1:0] {
        ASP_MODE_SHIFT,
        ASP_MODE_UART8,
        ASP_MODE_UART9_FIXED,
        ASP_MODE_UART9_VAR
    } asp_mode_type;

    typedef enum {
        ASP_RX_IDLE,
        ASP_RX_BUSY
    } asp_rx_state_type;

    typedef enum {
        ASP_TX_IDLE,
        ASP_TX_SEND
    } asp_tx_state_type;
endpackage

// [src/asp_baud_if.sv]
`timescale 1ns/1ps
interface asp_baud_if;
    logic [1:0] mode;
    logic rate_double;
    logic baud_generator_select;
    logic [1:0] timer1_prescale;
    logic [1:0] rps;
    logic [9:0] reload;
    logic [7:0] th1;
    logic tick;

    modport gen (input mode, rate_double, baud_generator_select, timer1_prescale, rps, reload, th1, output tick);
    modport user (output mode, rate_double, baud_generator_select, timer1_prescale, rps, reload, th1, input tick);
endinterface

// [src/asp_baud_gen.sv]
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_baud_gen
    import asp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration in, sixteen-times bit rate tick out
    asp_baud_if.gen bif
);
    logic [6:0] pre_div;
    logic [6:0] pre_cnt_r;
    logic pre_en;
    logic [9:0] cnt_r;
    logic [9:0] top;
    logic [9:0] reload;
    logic ovf;
    logic half_r;
    logic tick_r;

    // prescale select: fixed fraction, reload generator or timer 1
    always_comb begin
        pre_div = `ASP_PRE_12;
        if (bif.mode == `ASP_MODE_2) begin
            pre_div = bif.rate_double ? `ASP_PRE_2 : `ASP_PRE_4;
        end else if (bif.baud_generator_select) begin
            pre_div = (bif.rps == `ASP_RPS_32) ? `ASP_PRE_2 : `ASP_PRE_4;
            if (bif.rate_double) begin
                pre_div = pre_div >> 1;
            end
        end else begin
            case (bif.timer1_prescale)
                `ASP_TIMER1_PRESCALE_1: pre_div = `ASP_PRE_1;
                `ASP_TIMER1_PRESCALE_96: pre_div = `ASP_PRE_96;
                default: pre_div = `ASP_PRE_12;
            endcase
        end
    end

    assign pre_en = (pre_cnt_r >= (pre_div - `ASP_PRE_1));
    assign top = bif.baud_generator_select ? `ASP_TOP_RELOAD : `ASP_TOP_TIMER;
    assign reload = bif.baud_generator_select ? bif.reload : {2'h0, bif.th1};
    assign ovf = pre_en && (cnt_r >= top);
    assign bif.tick = tick_r;

    // free prescaler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_cnt_r <= 7'h00;
        end else if (pre_en) begin
            pre_cnt_r <= 7'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + `ASP_PRE_1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= `ASP_RST_RELOAD;
        end else if (ovf) begin
            cnt_r <= reload;
        end else if (pre_en) begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

    // timer 1 overflow halving when rate is not doubled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_r <= 1'b0;
        end else if (ovf && !bif.baud_generator_select) begin
            half_r <= ~half_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_r <= 1'b0;
        end else if (bif.mode == `ASP_MODE_2) begin
            tick_r <= pre_en;
        end else if (bif.baud_generator_select) begin
            tick_r <= ovf;
        end else begin
            tick_r <= ovf && (bif.rate_double || half_r);
        end
    end
endmodule

// [src/asp_serial_port.sv]
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_serial_port
    import asp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // serial line
    input wire logic serial_receive_pin,
    output logic serial_transmit_pin,
    // interrupt
    output logic irq
);
    asp_baud_if bif ();

    // control, baud, receive buffer and interrupt register fields
    asp_mode_type mode_r;
    logic multiprocessor_enable_r, receive_enable_r, transmit_ninth_bit_r;
    logic received_ninth_bit_r, transmit_done_flag_r, receive_done_flag_r;
    logic rate_double_r, baud_generator_select_r;
    logic [1:0] timer1_prescale_r, reload_prescale_r;
    logic [9:0] baud_reload_value_r;
    logic [7:0] timer1_high_reload_r, rx_buf_r;
    logic [`ASP_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;

    // bus
    logic wait_r, wr_hit, wr_ctrl;
    logic [31:0] rdata_r, rdata_nxt;

    // receive path
    logic rx_meta_r, rx_sync_r, rx_prev_r;
    asp_rx_state_type rx_state_r;
    logic [3:0] rx_ph_r, rx_cnt_r;
    logic [9:0] rx_sh_r, rx_sh_nxt;
    logic nine_bit, rx_sample, rx_last, rx_done, rx_accept, rx_ninth;
    logic [7:0] rx_data;

    // transmit path
    asp_tx_state_type tx_state_r;
    logic [3:0] tx_ph_r, tx_left_r;
    logic [9:0] tx_sh_r;
    logic tx_r, tx_load, tx_edge, tx_done;

    assign nine_bit = (mode_r == ASP_MODE_UART9_FIXED) || (mode_r == ASP_MODE_UART9_VAR);

    // baud generator hookup
    assign bif.mode = mode_r;
    assign bif.rate_double = rate_double_r;
    assign bif.baud_generator_select = baud_generator_select_r;
    assign bif.timer1_prescale = timer1_prescale_r;
    assign bif.rps = reload_prescale_r;
    assign bif.reload = baud_reload_value_r;
    assign bif.th1 = timer1_high_reload_r;

    asp_baud_gen u_baud (
        .clk(clk),
        .rst(rst),
        .bif(bif)
    );

    // bus handshake: one wait cycle, then answer
    assign wr_hit = avs_write && !wait_r;
    assign wr_ctrl = wr_hit && (avs_address == `ASP_OFS_CTRL) && avs_byteenable[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
        end
    end

    // read data mux
    always_comb begin
        rdata_nxt = `ASP_RST_WORD;
        case (avs_address)
            `ASP_OFS_CTRL: rdata_nxt[7:0] = {mode_r, multiprocessor_enable_r,
                receive_enable_r, transmit_ninth_bit_r, received_ninth_bit_r,
                transmit_done_flag_r, receive_done_flag_r};
            `ASP_OFS_DATA: rdata_nxt[7:0] = rx_buf_r;
            `ASP_OFS_BAUD: rdata_nxt[5:0] = {reload_prescale_r, timer1_prescale_r,
                baud_generator_select_r, rate_double_r};
            `ASP_OFS_RELOAD: rdata_nxt[9:0] = baud_reload_value_r;
            `ASP_OFS_T1RELOAD: rdata_nxt[7:0] = timer1_high_reload_r;
            `ASP_OFS_IRQ_STAT: rdata_nxt[`ASP_IRQ_W-1:0] = irq_stat_r;
            `ASP_OFS_IRQ_MASK: rdata_nxt[`ASP_IRQ_W-1:0] = irq_mask_r;
            default: rdata_nxt = `ASP_RST_WORD;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= `ASP_RST_WORD;
        end else if (avs_read && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;

    // software-written control fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= ASP_MODE_SHIFT;
            multiprocessor_enable_r <= 1'b0;
            receive_enable_r <= 1'b0;
            transmit_ninth_bit_r <= 1'b0;
        end else if (wr_ctrl) begin
            mode_r <= asp_mode_type'(avs_writedata[`ASP_CTRL_MODE_HI:`ASP_CTRL_MODE_LO]);
            multiprocessor_enable_r <= avs_writedata[`ASP_CTRL_MPE];
            receive_enable_r <= avs_writedata[`ASP_CTRL_REN];
            transmit_ninth_bit_r <= avs_writedata[`ASP_CTRL_TB8];
        end
    end

    // done flags: hardware sets, set beats a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            transmit_done_flag_r <= 1'b0;
            receive_done_flag_r <= 1'b0;
        end else begin
            if (tx_done) begin
                transmit_done_flag_r <= 1'b1;
            end else if (wr_ctrl) begin
                transmit_done_flag_r <= avs_writedata[`ASP_CTRL_TI];
            end
            if (rx_accept) begin
                receive_done_flag_r <= 1'b1;
            end else if (wr_ctrl) begin
                receive_done_flag_r <= avs_writedata[`ASP_CTRL_RI];
            end
        end
    end

    // baud configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_double_r <= 1'b0;
            baud_generator_select_r <= 1'b0;
            timer1_prescale_r <= 2'h0;
            reload_prescale_r <= 2'h0;
            baud_reload_value_r <= `ASP_RST_RELOAD;
            timer1_high_reload_r <= `ASP_RST_BYTE;
        end else if (wr_hit) begin
            if (avs_address == `ASP_OFS_BAUD && avs_byteenable[0]) begin
                rate_double_r <= avs_writedata[`ASP_BAUD_RATE_DOUBLE];
                baud_generator_select_r <= avs_writedata[`ASP_BAUD_BAUD_GENERATOR_SELECT];
                timer1_prescale_r <= avs_writedata[`ASP_BAUD_TIMER1_PRESCALE_HI:`ASP_BAUD_TIMER1_PRESCALE_LO];
                reload_prescale_r <= avs_writedata[`ASP_BAUD_RPS_HI:`ASP_BAUD_RPS_LO];
            end
            if (avs_address == `ASP_OFS_RELOAD && avs_byteenable[0]) begin
                baud_reload_value_r[7:0] <= avs_writedata[7:0];
            end
            if (avs_address == `ASP_OFS_RELOAD && avs_byteenable[1]) begin
                baud_reload_value_r[9:8] <= avs_writedata[9:8];
            end
            if (avs_address == `ASP_OFS_T1RELOAD && avs_byteenable[0]) begin
                timer1_high_reload_r <= avs_writedata[7:0];
            end
        end
    end

    // interrupt status, write one to clear, set wins
    assign irq_set = {rx_accept, tx_done};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= `ASP_RST_IRQ;
            irq_mask_r <= `ASP_RST_IRQ;
            irq <= 1'b0;
        end else begin
            if (wr_hit && avs_address == `ASP_OFS_IRQ_STAT && avs_byteenable[0]) begin
                irq_stat_r <= (irq_stat_r & ~avs_writedata[`ASP_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            if (wr_hit && avs_address == `ASP_OFS_IRQ_MASK && avs_byteenable[0]) begin
                irq_mask_r <= avs_writedata[`ASP_IRQ_W-1:0];
            end
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // receive pin synchroniser and edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_meta_r <= serial_receive_pin;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    // receive decode at mid-bit sample
    assign rx_sample = bif.tick && (rx_ph_r == `ASP_PH_SAMPLE);
    assign rx_sh_nxt = {rx_sync_r, rx_sh_r[9:1]};
    assign rx_last = rx_cnt_r == (nine_bit ? `ASP_RXN_9BIT : `ASP_RXN_8BIT);
    assign rx_done = (rx_state_r == ASP_RX_BUSY) && rx_sample && rx_last;
    // byte and stop bit; ninth bit
    assign rx_data = nine_bit ? rx_sh_nxt[7:0] : rx_sh_nxt[8:1];
    assign rx_ninth = rx_sh_nxt[8];
    // multiprocessor filter, buffer must be free
    assign rx_accept = rx_done && !receive_done_flag_r &&
        (!multiprocessor_enable_r || (nine_bit ? rx_ninth : rx_sh_nxt[9]));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state_r <= ASP_RX_IDLE;
            rx_ph_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= 10'h3ff;
        end else begin
            unique case (rx_state_r)
                ASP_RX_IDLE: begin
                    if (receive_enable_r && mode_r != ASP_MODE_SHIFT &&
                        rx_prev_r && !rx_sync_r) begin
                        rx_state_r <= ASP_RX_BUSY;
                        rx_ph_r <= 4'h0;
                        rx_cnt_r <= 4'h0;
                    end
                end
                ASP_RX_BUSY: begin
                    if (bif.tick) begin
                        rx_ph_r <= rx_ph_r + 4'h1;
                    end
                    if (rx_sample) begin
                        if (rx_cnt_r == 4'h0 && rx_sync_r) begin
                            rx_state_r <= ASP_RX_IDLE;
                        end else if (rx_last) begin
                            rx_state_r <= ASP_RX_IDLE;
                        end
                        if (rx_cnt_r != 4'h0) begin
                            rx_sh_r <= rx_sh_nxt;
                        end
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                    end
                end
            endcase
        end
    end

    // receive holding register and stored ninth bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_buf_r <= `ASP_RST_BYTE;
            received_ninth_bit_r <= 1'b0;
        end else if (rx_accept) begin
            rx_buf_r <= rx_data;
            received_ninth_bit_r <= nine_bit ? rx_ninth : rx_sh_nxt[9];
        end else if (wr_ctrl) begin
            received_ninth_bit_r <= avs_writedata[`ASP_CTRL_RB8];
        end
    end

    assign tx_load = wr_hit && avs_address == `ASP_OFS_DATA && avs_byteenable[0] &&
        mode_r != ASP_MODE_SHIFT && tx_state_r == ASP_TX_IDLE;
    assign tx_edge = bif.tick && (tx_ph_r == `ASP_PH_LAST);
    assign tx_done = (tx_state_r == ASP_TX_SEND) && tx_edge && (tx_left_r == 4'h0);

    // transmit shifter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_r <= ASP_TX_IDLE;
            tx_ph_r <= 4'h0;
            tx_left_r <= 4'h0;
            tx_sh_r <= 10'h3ff;
            tx_r <= 1'b1;
        end else begin
            unique case (tx_state_r)
                ASP_TX_IDLE: begin
                    if (tx_load) begin
                        tx_state_r <= ASP_TX_SEND;
                        tx_ph_r <= 4'h0;
                        tx_r <= 1'b0;
                        // ten-bit frame; eleven with ninth bit
                        tx_sh_r <= {1'b1, nine_bit ? transmit_ninth_bit_r : 1'b1,
                            avs_writedata[7:0]};
                        tx_left_r <= nine_bit ? `ASP_LEFT_9BIT : `ASP_LEFT_8BIT;
                    end
                end
                ASP_TX_SEND: begin
                    if (bif.tick) begin
                        tx_ph_r <= tx_ph_r + 4'h1;
                    end
                    if (tx_edge) begin
                        if (tx_left_r == 4'h0) begin
                            tx_state_r <= ASP_TX_IDLE;
                            tx_r <= 1'b1;
                        end else begin
                            tx_r <= tx_sh_r[0];
                            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                            tx_left_r <= tx_left_r - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    assign serial_transmit_pin = tx_r;
endmodule

// [verif/asp_serial_port_asserts.sv]
`timescale 1ns/1ps
module asp_serial_port_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // line and interrupt
    input wire logic serial_receive_pin,
    input wire logic serial_transmit_pin,
    input wire logic irq
);
    logic wr_ok;
    logic [4:0] ctrl_r;
    logic [1:0] mask_r;
    logic [7:0] low_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    // shadow of software-owned control bits and the mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= 5'h00;
            mask_r <= 2'h0;
        end else if (wr_ok && avs_address == 8'h00) begin
            ctrl_r <= avs_writedata[7:3];
        end else if (wr_ok && avs_address == 8'h18) begin
            mask_r <= avs_writedata[1:0];
        end
    end
    // length of the current low run on the transmit line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_r <= 8'h00;
        end else if (serial_transmit_pin) begin
            low_r <= 8'h00;
        end else if (low_r != 8'hff) begin
            low_r <= low_r + 8'h01;
        end
    end
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_REQ_ANSWER: assert property (s_req |=> s_ans)
        else $error("request not answered after one wait state");
    AST_IDLE_QUIET: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without a request");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 8'h18
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_BITS: assert property (avs_read && !avs_waitrequest && avs_address == 8'h00
        |-> avs_readdata[7:3] == ctrl_r)
        else $error("control read lost written bits");
    AST_READ_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    AST_START_LEN: assert property ($rose(serial_transmit_pin) |-> low_r >= 8'h08)
        else $error("low pulse on transmit line too short");
    AST_MODE0_QUIET: assert property ((ctrl_r[4:3] == 2'h0) [*2] |-> serial_transmit_pin)
        else $error("transmit line active in mode 0");
    AST_IRQ_MASKED: assert property ((mask_r == 2'h0) [*2] |-> !irq)
        else $error("interrupt high with all sources masked");
endmodule
bind asp_serial_port asp_serial_port_asserts u_asserts (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_receive_pin(serial_receive_pin), .serial_transmit_pin(serial_transmit_pin),
    .irq(irq)
);

// [verif/asp_serial_node.sv]
`timescale 1ns/1ps
module asp_serial_node (
    // clock
    input wire logic clk,
    // line from the port, line to the port
    input wire logic line_in,
    output logic line_out
);
    int bit_clks = 32;
    int nbits = 9;
    logic [10:0] frm;
    event frame_ev;
    initial line_out = 1'b1;
    // frame capture
    // mid-bit sampling, start bit lands in bit 0
    always begin
        @(negedge line_in);
        frm = 11'h000;
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i <= nbits; i++) begin
            frm[i] = line_in;
            if (i < nbits) repeat (bit_clks) @(posedge clk);
        end
        -> frame_ev;
    end
    // one frame, start bit first, then the line idles high
    task automatic send(input logic [10:0] bits);
        for (int i = 0; i <= nbits; i++) begin
            line_out <= bits[i];
            repeat (bit_clks) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask
endmodule

// [verif/asp_serial_port_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module asp_serial_port_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_line;
    logic tx_line;
    logic irq;
    logic [31:0] exp_q[$];
    logic [31:0] res_q[$];
    logic [31:0] got_v;
    logic [31:0] exp_v;
    logic [7:0] base;
    logic [7:0] d;
    logic tb8;
    logic nb;
    logic nine;
    int checks = 0;
    int err_total = 0;
    int cyc = 0;
    logic [7:0] cfg_baud[7] = '{8'h05, 8'h01, 8'h09, 8'h00, 8'h01, 8'h02, 8'h13};
    logic [7:0] cfg_mode[7] = '{8'h40, 8'h40, 8'h40, 8'h80, 8'h80, 8'hc0, 8'hc0};
    int cfg_clks[7] = '{32, 192, 1536, 64, 32, 64, 32};

    always #12.5 clk = ~clk;

    asp_serial_port u_asp_serial_port (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_receive_pin(rx_line), .serial_transmit_pin(tx_line), .irq(irq)
    );
    asp_serial_node u_asp_serial_node (.clk(clk), .line_in(tx_line), .line_out(rx_line));

    // every frame seen by the remote node becomes a result
    always @(u_asp_serial_node.frame_ev) res_q.push_back(32'(u_asp_serial_node.frm));

    // compare each result with the oldest expectation
    always @(posedge clk) begin
        while (res_q.size() > 0) begin
            got_v = res_q.pop_front();
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx;
            `CHK(got_v, exp_v)
        end
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        if (!w) res_q.push_back(avs_readdata);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // waits until irq is high; the hang guard ends the test if it never rises
    task automatic wait_irq();
        while (irq !== 1'b1) begin
            @(posedge clk);
        end
    endtask

    task automatic chk_irq(input logic v);
        repeat (2) @(posedge clk);
        exp_q.push_back(32'(v));
        res_q.push_back(32'(irq));
    endtask

    initial begin
        void'($urandom(32'h8a2b_1420));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
        // a data write in mode 0 starts nothing
        wr(8'h04, 32'ha5);
        repeat (40) @(posedge clk);
        rd(8'h14, 32'h0);
        wr(8'h18, 32'h3);
        // each rate source and modes 1 to 3: one frame out, one frame in
        for (int i = 0; i < 7; i++) begin
            nine = cfg_mode[i][7];
            tb8 = 1'($urandom);
            nb = 1'($urandom) | !nine;
            d = 8'($urandom);
            u_asp_serial_node.bit_clks = cfg_clks[i];
            u_asp_serial_node.nbits = nine ? 10 : 9;
            wr(8'h08, 32'(cfg_baud[i]));
            wr(8'h0c, i == 6 ? 32'h3fe : 32'h3ff);
            wr(8'h10, i == 0 ? 32'hfe : 32'hff);
            // the rate counter only takes a new reload after it overflows
            repeat (i == 5 ? 3200 : 300) @(posedge clk);
            base = cfg_mode[i] | 8'h10 | {4'h0, tb8 & nine, 3'h0};
            wr(8'h00, 32'(base));
            exp_q.push_back(nine ? 32'({1'b1, tb8, d, 1'b0}) : 32'({1'b1, d, 1'b0}));
            wr(8'h04, 32'(d));
            wait_irq();
            rd(8'h14, 32'h1);
            rd(8'h00, 32'(base | 8'h02));
            wr(8'h14, 32'h3);
            wr(8'h00, 32'(base));
            d = 8'($urandom);
            u_asp_serial_node.send({1'b1, nb, d, 1'b0});
            wait_irq();
            rd(8'h04, 32'(d));
            rd(8'h00, 32'(base | {5'h00, nb, 2'b01}));
            rd(8'h14, 32'h2);
            wr(8'h14, 32'h3);
        end
        // address filter in mode 3
        wr(8'h00, 32'hf0);
        u_asp_serial_node.send({2'b10, 8'h3c, 1'b0});
        repeat (40) @(posedge clk);
        rd(8'h00, 32'hf0);
        wr(8'h18, 32'h0);
        u_asp_serial_node.send({2'b11, 8'h5a, 1'b0});
        repeat (40) @(posedge clk);
        chk_irq(1'b0);
        rd(8'h14, 32'h2);
        rd(8'h00, 32'hf5);
        wr(8'h18, 32'h2);
        chk_irq(1'b1);
        wr(8'h14, 32'h2);
        chk_irq(1'b0);
        // receiver switched off
        wr(8'h00, 32'hc0);
        u_asp_serial_node.send({2'b11, 8'h96, 1'b0});
        repeat (40) @(posedge clk);
        rd(8'h14, 32'h0);
        rd(8'h00, 32'hc0);
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule
